/* File: opc_pkg.sv */
package opc_pkg;

	// Clock rate and the over-current delay step derived from it.
	localparam int CLK_HZ          = 40_000_000;
	localparam int OC_STEP_MS      = 1;
	localparam int OC_CYC_PER_STEP = CLK_HZ / 1000 * OC_STEP_MS;

	// Data widths of levels and status groups.
	localparam int LVL_W = 16;
	localparam int ST_W  = 8;

	// Register offsets, byte addresses on the register port.
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_VIMM  = 8'h04;
	localparam logic [7:0] A_VTRIG = 8'h08;
	localparam logic [7:0] A_CIMM  = 8'h0C;
	localparam logic [7:0] A_CTRIG = 8'h10;
	localparam logic [7:0] A_OVL   = 8'h14;
	localparam logic [7:0] A_OCDLY = 8'h18;
	localparam logic [7:0] A_CMD   = 8'h1C;
	localparam logic [7:0] A_STATE = 8'h20;
	localparam logic [7:0] A_OPER  = 8'h40;
	localparam logic [7:0] A_QUES  = 8'h60;

	// Offsets inside a status group, added to its base.
	localparam logic [7:0] G_COND = 8'h00;
	localparam logic [7:0] G_EN   = 8'h04;
	localparam logic [7:0] G_EVT  = 8'h08;
	localparam logic [7:0] G_RISE = 8'h0C;
	localparam logic [7:0] G_FALL = 8'h10;

	// Control and command bit positions.
	localparam int CB_OUT   = 0;
	localparam int CB_OCP   = 1;
	localparam int CB_VSTEP = 2;
	localparam int CB_CSTEP = 3;
	localparam int CB_PON   = 4;
	localparam int KB_CLR   = 0;
	localparam int KB_TRIG  = 1;
	localparam int KB_PRE   = 2;

	// Status condition bit positions.
	localparam int OB_CV  = 0;
	localparam int OB_CC  = 1;
	localparam int OB_OFF = 2;
	localparam int QB_OV  = 0;
	localparam int QB_OC  = 1;

	// Values after reset and percentage limits.
	localparam logic [15:0] LVL_RST   = 16'h0000;
	localparam logic [15:0] OCDLY_RST = 16'h0032;
	localparam int PCT_SET_MAX = 102;
	localparam int PCT_OVL_MAX = 120;
	localparam int PCT_FULL    = 100;

	// Regulation state of the output.
	typedef enum logic [2:0] {
		OPC_OFF = 3'b001,
		OPC_CV  = 3'b010,
		OPC_CC  = 3'b100
	} opc_reg_state_t;

endpackage

/* File: opc_status_group.sv */
`timescale 1ns/1ps
module opc_status_group
	import opc_pkg::*;
#(
	parameter int W = ST_W
) (
	// Clock and reset.
	input  wire logic         core_clk_i,
	input  wire logic         rst_n_i,
	// Live condition and register access.
	input  wire logic [W-1:0] cond_i,
	input  wire logic [W-1:0] wdata_i,
	input  wire logic         en_wr_i,
	input  wire logic         rise_wr_i,
	input  wire logic         fall_wr_i,
	input  wire logic         evt_rd_i,
	input  wire logic         preset_i,
	// Register contents.
	output logic      [W-1:0] en_o,
	output logic      [W-1:0] evt_o,
	output logic      [W-1:0] rising_edge_filter_o,
	output logic      [W-1:0] falling_edge_filter_o
);

	logic [W-1:0] cond_q;
	logic [W-1:0] hit;
	logic         seen_q;

	// Edges pass only where their filter bit is set.
	// The first edge after reset only loads the history, so a condition
	// that is already high out of reset is not taken for a fresh edge.
	assign hit = ((cond_i & ~cond_q & rising_edge_filter_o)
		| (~cond_i & cond_q & falling_edge_filter_o)) & {W{seen_q}};

	// A read clears the event bits, but an edge in the same cycle wins.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cond_q <= '0;
			evt_o  <= '0;
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
			cond_q <= cond_i;
			evt_o  <= (evt_o & ~{W{evt_rd_i}}) | hit;
		end
	end

	// Preset clears every enable bit and arms only rising edges.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_o                  <= '0;
			rising_edge_filter_o  <= '1;
			falling_edge_filter_o <= '0;
		end else if (preset_i) begin
			en_o                  <= '0;
			rising_edge_filter_o  <= '1;
			falling_edge_filter_o <= '0;
		end else begin
			if (en_wr_i)
				en_o <= wdata_i;
			if (rise_wr_i)
				rising_edge_filter_o <= wdata_i;
			if (fall_wr_i)
				falling_edge_filter_o <= wdata_i;
		end
	end

endmodule

/* File: opc_oc_timer.sv */
`timescale 1ns/1ps
module opc_oc_timer
	import opc_pkg::*;
#(
	parameter int CYC_PER_MS = OC_CYC_PER_STEP
) (
	// Clock and reset.
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// Arming condition and programmed delay in milliseconds.
	input  wire logic             arm_i,
	input  wire logic [LVL_W-1:0] delay_ms_i,
	// Level, high once the delay has run out while armed.
	output logic                  trip_o
);

	localparam int CW = $clog2(CYC_PER_MS + 1);

	logic [CW-1:0]    cyc_q;
	logic [LVL_W-1:0] ms_q;
	logic             tick;
	logic             done;

	if (CYC_PER_MS < 1)
		$error("opc_oc_timer: CYC_PER_MS must be at least one");

	assign tick = (cyc_q == CW'(CYC_PER_MS - 1));
	assign done = (ms_q >= delay_ms_i);

	// Dropping the arm restarts the count from zero.
	// The trip waits for the whole delay in millisecond steps.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_q  <= '0;
			ms_q   <= '0;
			trip_o <= 1'b0;
		end else if (!arm_i) begin
			cyc_q  <= '0;
			ms_q   <= '0;
			trip_o <= 1'b0;
		end else if (done) begin
			trip_o <= 1'b1;
		end else if (tick) begin
			cyc_q <= '0;
			ms_q  <= ms_q + 16'h0001;
		end else begin
			cyc_q <= cyc_q + CW'(1);
		end
	end

endmodule

/* File: opc_top.sv */
`timescale 1ns/1ps
module opc_top
	import opc_pkg::*;
#(
	parameter int V_RATING   = 50000,
	parameter int I_RATING   = 50000,
	parameter int CYC_PER_MS = OC_CYC_PER_STEP
) (
	// Clock and reset.
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// Register port.
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [31:0]      reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [31:0]      reg_rdata_o,
	// Regulator feedback and trigger pins.
	input  wire logic             cc_reg_i,
	input  wire logic [LVL_W-1:0] meas_volt_i,
	input  wire logic             step_trig_i,
	// Non-volatile store.
	input  wire logic             recall_slot_zero_i,
	input  wire logic             slot0_out_en_i,
	input  wire logic [LVL_W-1:0] slot0_volt_i,
	input  wire logic [LVL_W-1:0] slot0_curr_i,
	output logic                  recall_slot_zero_o,
	output logic                  recall_slot_zero_wr_o,
	// Regulator programming and status.
	output logic                  out_enable_o,
	output logic      [LVL_W-1:0] volt_set_o,
	output logic      [LVL_W-1:0] curr_set_o,
	output logic                  overvoltage_flag_o,
	output logic                  overcurrent_flag_o,
	output logic                  constant_voltage_state_o,
	output logic                  constant_current_state_o
);

	localparam int VMAX_I = V_RATING * PCT_SET_MAX / PCT_FULL;
	localparam int IMAX_I = I_RATING * PCT_SET_MAX / PCT_FULL;
	localparam int OVL_I  = V_RATING * PCT_OVL_MAX / PCT_FULL;
	localparam logic [LVL_W-1:0] VSET_MAX = LVL_W'(VMAX_I);
	localparam logic [LVL_W-1:0] ISET_MAX = LVL_W'(IMAX_I);
	localparam logic [LVL_W-1:0] OVL_MAX  = LVL_W'(OVL_I);
	localparam int SYN_W = 4 + 3 * LVL_W;

	// Limits above the level width would wrap silently.
	if (OVL_I > 65535 || IMAX_I > 65535 || V_RATING < 1 || I_RATING < 1)
		$error("opc_top: ratings do not fit the level width");

	function automatic logic [LVL_W-1:0] clamp(
		input logic [LVL_W-1:0] v,
		input logic [LVL_W-1:0] m
	);
		return (v > m) ? m : v;
	endfunction

	// Pin synchroniser; only the second stage is read.
	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic             cc_s;
	logic             trig_s;
	logic             pon_s;
	logic             s0en_s;
	logic [LVL_W-1:0] meas_s;
	logic [LVL_W-1:0] s0v_s;
	logic [LVL_W-1:0] s0c_s;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			syn1_q <= '0;
			syn2_q <= '0;
		end else begin
			syn1_q <= {cc_reg_i, step_trig_i, recall_slot_zero_i,
				slot0_out_en_i, meas_volt_i, slot0_volt_i, slot0_curr_i};
			syn2_q <= syn1_q;
		end
	end

	assign {cc_s, trig_s, pon_s, s0en_s, meas_s, s0v_s, s0c_s} = syn2_q;

	// Address decode of the register port.
	wire wr_ctrl  = reg_wr_i && (reg_addr_i == A_CTRL);
	wire wr_vimm  = reg_wr_i && (reg_addr_i == A_VIMM);
	wire wr_vtrig = reg_wr_i && (reg_addr_i == A_VTRIG);
	wire wr_cimm  = reg_wr_i && (reg_addr_i == A_CIMM);
	wire wr_ctrig = reg_wr_i && (reg_addr_i == A_CTRIG);
	wire wr_ovl   = reg_wr_i && (reg_addr_i == A_OVL);
	wire wr_ocdly = reg_wr_i && (reg_addr_i == A_OCDLY);
	wire wr_cmd   = reg_wr_i && (reg_addr_i == A_CMD);
	wire [LVL_W-1:0] wlvl = reg_wdata_i[LVL_W-1:0];
	wire [ST_W-1:0]  wst  = reg_wdata_i[ST_W-1:0];
	wire cmd_clr  = wr_cmd && reg_wdata_i[KB_CLR];
	wire cmd_trig = wr_cmd && reg_wdata_i[KB_TRIG];
	wire cmd_pre  = wr_cmd && reg_wdata_i[KB_PRE];

	// Programmed state.
	logic             out_req_q;
	logic             ocp_en_q;
	logic             vstep_q;
	logic             cstep_q;
	logic [LVL_W-1:0] vimm_q;
	logic [LVL_W-1:0] vtrig_q;
	logic [LVL_W-1:0] vact_q;
	logic [LVL_W-1:0] cimm_q;
	logic [LVL_W-1:0] ctrig_q;
	logic [LVL_W-1:0] cact_q;
	logic [LVL_W-1:0] overvoltage_limit_q;
	logic [LVL_W-1:0] ocdly_q;
	logic [1:0]       pu_q;
	logic             trig_prev_q;
	logic             ov_q;
	logic             oc_q;
	opc_reg_state_t   state_q;

	// Power-up waits for the store inputs to cross the synchroniser.
	wire pu_load = (pu_q == 2'h2);
	wire recall  = pu_load && pon_s;
	wire trig_ev = (trig_s && !trig_prev_q) || cmd_trig;
	wire active  = out_req_q && !ov_q && !oc_q;

	// Trip causes and the clear qualification.
	wire ov_cause = (meas_s > overvoltage_limit_q);
	wire ov_set   = active && ov_cause;
	wire oc_trip;
	wire oc_set   = active && oc_trip;
	wire clr_ok   = cmd_clr && !ov_cause && !cc_s;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pu_q        <= 2'h0;
			trig_prev_q <= 1'b0;
		end else begin
			pu_q        <= (pu_q == 2'h3) ? pu_q : pu_q + 2'h1;
			trig_prev_q <= trig_s;
		end
	end

	// Output enable and control bits; reset leaves the output off.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_req_q <= 1'b0;
			ocp_en_q  <= 1'b0;
			vstep_q   <= 1'b0;
			cstep_q   <= 1'b0;
		end else if (wr_ctrl) begin
			out_req_q <= reg_wdata_i[CB_OUT];
			ocp_en_q  <= reg_wdata_i[CB_OCP];
			vstep_q   <= reg_wdata_i[CB_VSTEP];
			cstep_q   <= reg_wdata_i[CB_CSTEP];
		end else if (recall) begin
			out_req_q <= s0en_s;
		end
	end

	// Kept power-on choice, read back at power-up and written out.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			recall_slot_zero_o    <= 1'b0;
			recall_slot_zero_wr_o <= 1'b0;
		end else begin
			recall_slot_zero_wr_o <= wr_ctrl;
			if (wr_ctrl)
				recall_slot_zero_o <= reg_wdata_i[CB_PON];
			else if (pu_load)
				recall_slot_zero_o <= pon_s;
		end
	end

	// Voltage levels, clamped to 102 percent; step mode copies on trigger.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vimm_q  <= LVL_RST;
			vtrig_q <= LVL_RST;
			vact_q  <= LVL_RST;
		end else begin
			if (wr_vtrig)
				vtrig_q <= clamp(wlvl, VSET_MAX);
			if (wr_vimm) begin
				vimm_q <= clamp(wlvl, VSET_MAX);
				vact_q <= clamp(wlvl, VSET_MAX);
			end else if (recall) begin
				vimm_q <= clamp(s0v_s, VSET_MAX);
				vact_q <= clamp(s0v_s, VSET_MAX);
			end else if (trig_ev && vstep_q) begin
				vact_q <= vtrig_q;
			end
		end
	end

	// Current levels, same scheme; the active level is the trip point.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cimm_q  <= LVL_RST;
			ctrig_q <= LVL_RST;
			cact_q  <= LVL_RST;
		end else begin
			if (wr_ctrig)
				ctrig_q <= clamp(wlvl, ISET_MAX);
			if (wr_cimm) begin
				cimm_q <= clamp(wlvl, ISET_MAX);
				cact_q <= clamp(wlvl, ISET_MAX);
			end else if (recall) begin
				cimm_q <= clamp(s0c_s, ISET_MAX);
				cact_q <= clamp(s0c_s, ISET_MAX);
			end else if (trig_ev && cstep_q) begin
				cact_q <= ctrig_q;
			end
		end
	end

	// Protection settings.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overvoltage_limit_q <= OVL_MAX;
			ocdly_q             <= OCDLY_RST;
		end else begin
			if (wr_ovl)
				overvoltage_limit_q <= clamp(wlvl, OVL_MAX);
			if (wr_ocdly)
				ocdly_q <= wlvl;
		end
	end

	// The timer arms only while current regulation holds the set limit.
	opc_oc_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_oc_timer (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.arm_i      (ocp_en_q && active && cc_s),
		.delay_ms_i (ocdly_q),
		.trip_o     (oc_trip)
	);

	// Fault latches; a trip in the clearing cycle wins over the clear.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ov_q <= 1'b0;
			oc_q <= 1'b0;
		end else begin
			ov_q <= ov_set || (ov_q && !clr_ok);
			oc_q <= oc_set || (oc_q && !clr_ok);
		end
	end

	// Regulation state, leaving off as soon as the output is active.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= OPC_OFF;
		end else begin
			case (state_q)
			OPC_OFF:
				if (active)
					state_q <= cc_s ? OPC_CC : OPC_CV;
			OPC_CV:
				if (!active)
					state_q <= OPC_OFF;
				else if (cc_s)
					state_q <= OPC_CC;
			OPC_CC:
				if (!active)
					state_q <= OPC_OFF;
				else if (!cc_s)
					state_q <= OPC_CV;
			default:
				state_q <= OPC_OFF;
			endcase
		end
	end

	// Regulator outputs; an inactive output is programmed to zero.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_enable_o             <= 1'b0;
			volt_set_o               <= LVL_RST;
			curr_set_o               <= LVL_RST;
			overvoltage_flag_o       <= 1'b0;
			overcurrent_flag_o       <= 1'b0;
			constant_voltage_state_o <= 1'b0;
			constant_current_state_o <= 1'b0;
		end else begin
			out_enable_o             <= active;
			volt_set_o               <= active ? vact_q : LVL_RST;
			curr_set_o               <= active ? cact_q : LVL_RST;
			overvoltage_flag_o       <= ov_q;
			overcurrent_flag_o       <= oc_q;
			constant_voltage_state_o <= (state_q == OPC_CV);
			constant_current_state_o <= (state_q == OPC_CC);
		end
	end

	// Status groups fed from regulation state and fault latches.
	logic [ST_W-1:0] op_cond;
	logic [ST_W-1:0] qu_cond;
	logic [ST_W-1:0] op_en, op_evt, op_rise, op_fall;
	logic [ST_W-1:0] qu_en, qu_evt, qu_rise, qu_fall;

	always_comb begin
		op_cond         = '0;
		qu_cond         = '0;
		op_cond[OB_CV]  = (state_q == OPC_CV);
		op_cond[OB_CC]  = (state_q == OPC_CC);
		op_cond[OB_OFF] = (state_q == OPC_OFF);
		qu_cond[QB_OV]  = ov_q;
		qu_cond[QB_OC]  = oc_q;
	end

	// One group per status set, each with its own edge filters.
	for (genvar g = 0; g < 2; g++) begin : g_grp
		localparam logic [7:0] BASE = (g == 0) ? A_OPER : A_QUES;
		wire [ST_W-1:0] en_w, evt_w, rise_w, fall_w;
		opc_status_group #(
			.W (ST_W)
		) u_grp (
			.core_clk_i            (core_clk_i),
			.rst_n_i               (rst_n_i),
			.cond_i                ((g == 0) ? op_cond : qu_cond),
			.wdata_i               (wst),
			.en_wr_i   (reg_wr_i && reg_addr_i == BASE + G_EN),
			.rise_wr_i (reg_wr_i && reg_addr_i == BASE + G_RISE),
			.fall_wr_i (reg_wr_i && reg_addr_i == BASE + G_FALL),
			.evt_rd_i  (reg_rd_i && reg_addr_i == BASE + G_EVT),
			.preset_i              (cmd_pre),
			.en_o                  (en_w),
			.evt_o                 (evt_w),
			.rising_edge_filter_o  (rise_w),
			.falling_edge_filter_o (fall_w)
		);
	end

	assign {op_en, op_evt, op_rise, op_fall} =
		{g_grp[0].en_w, g_grp[0].evt_w, g_grp[0].rise_w, g_grp[0].fall_w};
	assign {qu_en, qu_evt, qu_rise, qu_fall} =
		{g_grp[1].en_w, g_grp[1].evt_w, g_grp[1].rise_w, g_grp[1].fall_w};

	// Read mux; unmapped addresses read as zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_addr_i == A_CTRL)
			rd_mux[4:0] = {recall_slot_zero_o, cstep_q, vstep_q,
				ocp_en_q, out_req_q};
		else if (reg_addr_i == A_VIMM)
			rd_mux[LVL_W-1:0] = vimm_q;
		else if (reg_addr_i == A_VTRIG)
			rd_mux[LVL_W-1:0] = vtrig_q;
		else if (reg_addr_i == A_CIMM)
			rd_mux[LVL_W-1:0] = cimm_q;
		else if (reg_addr_i == A_CTRIG)
			rd_mux[LVL_W-1:0] = ctrig_q;
		else if (reg_addr_i == A_OVL)
			rd_mux[LVL_W-1:0] = overvoltage_limit_q;
		else if (reg_addr_i == A_OCDLY)
			rd_mux[LVL_W-1:0] = ocdly_q;
		else if (reg_addr_i == A_STATE)
			rd_mux[4:0] = {oc_q, ov_q, state_q};
		else if (reg_addr_i == A_OPER + G_COND)
			rd_mux[ST_W-1:0] = op_cond;
		else if (reg_addr_i == A_OPER + G_EN)
			rd_mux[ST_W-1:0] = op_en;
		else if (reg_addr_i == A_OPER + G_EVT)
			rd_mux[ST_W-1:0] = op_evt;
		else if (reg_addr_i == A_OPER + G_RISE)
			rd_mux[ST_W-1:0] = op_rise;
		else if (reg_addr_i == A_OPER + G_FALL)
			rd_mux[ST_W-1:0] = op_fall;
		else if (reg_addr_i == A_QUES + G_COND)
			rd_mux[ST_W-1:0] = qu_cond;
		else if (reg_addr_i == A_QUES + G_EN)
			rd_mux[ST_W-1:0] = qu_en;
		else if (reg_addr_i == A_QUES + G_EVT)
			rd_mux[ST_W-1:0] = qu_evt;
		else if (reg_addr_i == A_QUES + G_RISE)
			rd_mux[ST_W-1:0] = qu_rise;
		else if (reg_addr_i == A_QUES + G_FALL)
			rd_mux[ST_W-1:0] = qu_fall;
	end

	// Read data stands for exactly the cycle after the strobe.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 32'h0000_0000;
		else
			reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
	end

	// Checks on the protection and level paths.
	AST_OFF_ZERO: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) !active |=> (volt_set_o == 16'h0000
		&& curr_set_o == 16'h0000 && !out_enable_o))
		else $error("inactive output not driven to zero");
	AST_ON_STATE: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) active |=> (state_q != OPC_OFF) ##1
		(constant_voltage_state_o || constant_current_state_o))
		else $error("enabled output still reported off");
	AST_PU_RECALL: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (recall && s0en_s && !wr_ctrl) |=> out_req_q)
		else $error("slot zero output state not restored");
	AST_CLEAR: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (clr_ok && !ov_set && !oc_set)
		|=> (!ov_q && !oc_q && (active == out_req_q)))
		else $error("protection clear did not release the output");
	AST_CLEAR_BLOCK: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (ov_q && ov_cause) |=> ov_q)
		else $error("fault cleared while its cause remains");
	AST_STEP_V: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (trig_ev && vstep_q && !wr_vimm && !recall)
		|=> vact_q == $past(vtrig_q))
		else $error("step trigger did not load triggered voltage");
	AST_HOLD_LEVEL_MODE_I: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) (trig_ev && !cstep_q && !wr_cimm && !recall)
		|=> $stable(cact_q))
		else $error("hold_level_mode mode current changed on trigger");
	AST_OV_TRIP: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) ov_set |=> ov_q ##1 (!out_enable_o
		&& overvoltage_flag_o))
		else $error("over-voltage did not disable the output");
	AST_OC_TRIP: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) oc_set |=> oc_q ##1 !out_enable_o)
		else $error("over-current did not disable the output");
	AST_LVL_MAX: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) vimm_q <= VSET_MAX && cimm_q <= ISET_MAX
		&& vtrig_q <= VSET_MAX && ctrig_q <= ISET_MAX)
		else $error("setpoint above 102 percent of rating");

endmodule

/* File: opc_regulator_model.sv */
`timescale 1ns/1ps
// Regulator behind the block: follows the programmed levels.
module opc_regulator_model (
	// Programming from the block.
	input  wire logic        en_i,
	input  wire logic [15:0] volt_set_i,
	input  wire logic [15:0] curr_set_i,
	// Load demand and outside voltage.
	input  wire logic [15:0] load_i,
	input  wire logic [15:0] ext_volt_i,
	// Feedback.
	output logic             cc_o,
	output logic      [15:0] meas_o
);
	// Outside voltage stays on a disabled output, so a cause can persist.
	assign meas_o = (en_i ? volt_set_i : 16'h0000) + ext_volt_i;
	assign cc_o = en_i && (load_i > curr_set_i);
endmodule

/* File: opc_top_test.sv */
`timescale 1ns/1ps
module opc_top_test;
	import opc_pkg::*;
	localparam int VMAX = 50000 * PCT_SET_MAX / PCT_FULL;
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        trig = 1'b0, pu = 1'b0, s0en = 1'b1, cc, oe, ovf, ocf;
	logic        pz, pzw, cvs, ccs;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wd = 32'h0, rdata, d;
	logic [15:0] vs, cs, meas, load = 16'h0, ext = 16'h0;
	int          fail_count = 0, comparisons = 0, cyc = 0, mv, mt;
	opc_top #(.CYC_PER_MS(4)) dut (.core_clk_i(clk), .rst_n_i(rst_n),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .cc_reg_i(cc), .meas_volt_i(meas),
		.step_trig_i(trig), .recall_slot_zero_i(pu),
		.slot0_out_en_i(s0en), .slot0_volt_i(16'h04D2),
		.slot0_curr_i(16'h01F4), .recall_slot_zero_o(pz),
		.recall_slot_zero_wr_o(pzw), .out_enable_o(oe),
		.volt_set_o(vs), .curr_set_o(cs), .overvoltage_flag_o(ovf),
		.overcurrent_flag_o(ocf), .constant_voltage_state_o(cvs),
		.constant_current_state_o(ccs));
	opc_regulator_model reg_model (.en_i(oe), .volt_set_i(vs),
		.curr_set_i(cs), .load_i(load), .ext_volt_i(ext), .cc_o(cc),
		.meas_o(meas));
	// Free-running clock at 40 MHz.
	initial begin
		forever #12.5 clk = ~clk;
	end
	// A hang is cut short well past the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a; wd <= v; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	initial begin
		void'($urandom(32'h5B05D521));
		wt(8);
		rst_n <= 1'b1;
		wt(4);
		chk("vset_off", vs, 32'h0);
		rdr(A_STATE); chk("state_rst", d, 32'h1);
		rdr(A_OPER + G_EVT); chk("oper_evt_rst", d, 32'h0);
		rdr(A_OCDLY); chk("ocdly_rst", d, 32'h32);
		rdr(A_OVL); chk("ovl_rst", d, 32'hEA60);
		rdr(A_VTRIG); chk("vtrig_rst", d, 32'h0);
		rdr(A_CTRIG); chk("ctrig_rst", d, 32'h0);
		rdr(8'hF0); chk("unmapped", d, 32'h0);
		wrr(A_VIMM, 32'hFFFF); rdr(A_VIMM); chk("vclamp", d, VMAX);
		wrr(A_CIMM, 32'hFFFF); rdr(A_CIMM); chk("cclamp", d, VMAX);
		mv = $urandom_range(VMAX); mt = $urandom_range(VMAX);
		wrr(A_VIMM, mv); wrr(A_VTRIG, mt);
		wrr(A_CIMM, 32'hFA0); wrr(A_CTRIG, 32'hBB8);
		wrr(A_CTRL, 32'h1); wt(3);
		chk("vset_on", vs, mv);
		chk("cv_on", cvs, 1'b1);
		rdr(A_STATE); chk("state_on", d, 32'h2);
		rdr(A_OPER + G_COND); chk("oper_cond", d, 32'h1);
		rdr(A_OPER + G_EVT); chk("oper_evt", d, 32'h1);
		wrr(A_CMD, 32'h2); wt(4);
		chk("vfix", vs, mv);
		chk("cfix", cs, 32'hFA0);
		wrr(A_CTRL, 32'hD); wt(1);
		trig <= 1'b1; wt(3); trig <= 1'b0; wt(6);
		chk("vstep", vs, mt);
		chk("cstep", cs, 32'hBB8);
		wrr(A_CTRL, 32'h1); wrr(A_VIMM, 32'h384); wrr(A_CIMM, 32'hFA0);
		wrr(A_OVL, 32'h3E8); wt(8);
		chk("ov_idle", ovf, 1'b0);
		ext <= 16'h0400; wt(8);
		chk("ov_trip", ovf, 1'b1);
		chk("ov_off", oe, 1'b0);
		chk("ov_zero", vs, 32'h0);
		rdr(A_QUES + G_EVT); chk("ques_evt", d & 32'h1, 32'h1);
		rdr(A_QUES + G_EVT); chk("ques_clr", d, 32'h0);
		wrr(A_CMD, 32'h1); wt(4);
		chk("ov_held", ovf, 1'b1);
		ext <= 16'h0000; wt(4);
		wrr(A_CMD, 32'h1); wt(4);
		chk("ov_clr", ovf, 1'b0);
		chk("ov_back", vs, 32'h384);
		wrr(A_OCDLY, 32'h3); wrr(A_CTRL, 32'h3);
		load <= 16'h0F9F; wt(24);
		chk("oc_below", ocf, 1'b0);
		for (int i = 0; i < 2; i++) begin
			load <= 16'hFFFF; wt(8); load <= 16'h0000; wt(4);
		end
		chk("oc_restart", ocf, 1'b0);
		load <= 16'hFFFF; wt(8);
		chk("oc_delay", ocf, 1'b0);
		chk("cc_on", ccs, 1'b1);
		wt(14);
		chk("oc_trip", ocf, 1'b1);
		chk("oc_off", oe, 1'b0);
		load <= 16'h0000;
		wrr(A_CMD, 32'h1); wt(4);
		chk("oc_back", oe, 1'b1);
		pu <= 1'b1; rst_n <= 1'b0; wt(2);
		rst_n <= 1'b1; wt(6);
		chk("pu_on", oe, 1'b1);
		chk("pu_volt", vs, 32'h4D2);
		chk("pu_keep", pz, 1'b1);
		wrr(A_CTRL, 32'h1);
		#1 chk("pon_wr", pzw, 1'b1);
		chk("pon_set", pz, 1'b0);
		s0en <= 1'b0; rst_n <= 1'b0; wt(2);
		rst_n <= 1'b1; wt(6);
		chk("pu_off", oe, 1'b0);
		finish_test();
	end
endmodule
